// file: hdl/compare_counter.sv
// timer of one channel, 16 or 32 bits wide depending on cascade
module compare_counter #(
  parameter int W = 32
) (
  input  wire logic         sys_clk_in,   // clock
  input  wire logic         rst_in,       // synchronous reset
  input  wire logic         run_in,       // count when high, hold clear when low
  input  wire logic         sync_in,      // restart from zero
  input  wire logic         wide_in,      // 32-bit mode
  input  wire logic [W-1:0] limit_in,     // last count of a period
  output logic      [W-1:0] count_out,    // current count
  output logic              wrap_out      // period ends this cycle
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic [W-1:0] cmp_v;

  initial begin
    if (W != 32) $error("compare_counter needs W of 32");
  end

  always_comb begin
    cmp_v = wide_in ? count_r : {16'h0000, count_r[15:0]};
    wrap_out = run_in && (cmp_v == limit_in);
    if (!run_in || sync_in || wrap_out) begin
      count_nxt = '0;
    end else begin
      count_nxt = count_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_out = count_r;
endmodule

// file: hdl/output_compare_control_two.sv
// Our own choices: the address map and the strobed register port.
module output_compare_control_two
  import compare_pkg::*;
#(
  parameter int          NSRC    = 32,
  parameter logic [31:0] SRC_MAP = 32'hffff_fffe  // bit n: code n is a real source
) (
  input  wire logic        sys_clk_in,     // 50 MHz clock
  input  wire logic        rst_in,         // synchronous reset, high
  input  wire logic [3:0]  addr_in,        // register index
  input  wire logic [15:0] wdata_in,       // write data
  input  wire logic        wr_in,          // write strobe
  input  wire logic        rd_in,          // read strobe
  output logic      [15:0] rdata_out,      // read data, cycle after strobe
  input  wire logic [NSRC-1:0] src_in,     // trigger/sync source pulses
  input  wire logic        fault_in,       // fault source, high active
  input  wire logic        partner_wrap_in, // period end of partner channel
  output logic             pin_o_out,      // compare pin level
  output logic             pin_oe_out,     // compare pin drive enable
  output logic             trig_out,       // trigger-out pulse
  output logic             irq_out         // interrupt level
);
  import compare_pkg::*;

  initial begin
    if (NSRC != 32) $error("source select needs 32 sources");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ctrl2_r, ctrl2_nxt;
  logic        enable_r, enable_nxt;
  logic [31:0] cmp_r, cmp_nxt;
  logic [31:0] per_r, per_nxt;
  logic        fault_r, fault_nxt;
  logic        flag_r, flag_nxt;
  logic        running_r, running_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        pin_r, pin_nxt;
  logic        oe_r, oe_nxt;
  logic        trig_r, trig_nxt;
  logic [31:0] count_w;
  logic        wrap_w;
  logic        src_hit;
  logic        period_edge;
  logic        raw_out;
  logic [IRQ_W-1:0] events;

  // mapping gate per source, so an unmapped code can never start or restart the timer
  logic [NSRC-1:0] src_valid;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      assign src_valid[g] = src_in[g] & SRC_MAP[g];
    end
  endgenerate

  assign src_hit = src_valid[ctrl2_r[SRC_MSB:0]];

  compare_counter #(.W(32)) u_counter (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .run_in     (running_r),
    .sync_in    (!ctrl2_r[BIT_TRIG_SEL] && src_hit),
    .wide_in    (ctrl2_r[BIT_CASCADE]),
    .limit_in   (ctrl2_r[BIT_CASCADE] ? per_r : {16'h0000, per_r[15:0]}),
    .count_out  (count_w),
    .wrap_out   (wrap_w)
  );

  // in cascade the pair ends a period only when both halves do
  assign period_edge = ctrl2_r[BIT_CASCADE] ? (wrap_w && partner_wrap_in) : wrap_w;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    ctrl2_nxt   = ctrl2_r;
    enable_nxt  = enable_r;
    cmp_nxt     = cmp_r;
    per_nxt     = per_r;
    mask_nxt    = mask_r;
    fault_nxt   = fault_r;
    flag_nxt    = flag_r;
    running_nxt = running_r;
    trig_nxt    = 1'b0;
    rdata_nxt   = 16'h0000;
    events      = '0;

    if (wr_in) begin
      case (addr_in)
        ADDR_CTRL2:    ctrl2_nxt = (wdata_in & CTRL2_WMASK) | (ctrl2_r & ~CTRL2_WMASK);
        ADDR_CTRL1:    enable_nxt = wdata_in[BIT_ENABLE];
        ADDR_COMPARE:  cmp_nxt[15:0] = wdata_in;
        ADDR_PERIOD:   per_nxt[15:0] = wdata_in;
        ADDR_IRQ_MASK: mask_nxt = wdata_in[IRQ_W-1:0];
        ADDR_TIMER:    begin
          cmp_nxt[31:16] = wdata_in;
          per_nxt[31:16] = wdata_in;
        end
        ADDR_FAULT:    begin
          if (!wdata_in[BIT_FAULT_FLAG]) flag_nxt = 1'b0;
        end
        default:       ;
      endcase
    end

    // switching off emits a single trigger pulse
    if (enable_r && !enable_nxt) begin
      trig_nxt = 1'b1;
      events[IRQ_OFF_TRIG] = 1'b1;
    end

    // trigger mode waits for the source; sync mode runs whenever enabled
    if (!enable_r) begin
      running_nxt = 1'b0;
    end else if (!ctrl2_r[BIT_TRIG_SEL]) begin
      running_nxt = 1'b1;
    end else if (src_hit) begin
      running_nxt = 1'b1;
    end
    if (wr_in && addr_in == ADDR_CTRL2 && !wdata_in[BIT_TRIG_STATUS]) begin
      running_nxt = 1'b0;
    end
    ctrl2_nxt[BIT_TRIG_STATUS] = running_nxt;

    // fault entry; the flag is set even while a clear is written
    if (fault_in) begin
      fault_nxt = 1'b1;
      flag_nxt  = 1'b1;
      if (!fault_r) events[IRQ_FAULT] = 1'b1;
    end else if (fault_r && period_edge) begin
      if (ctrl2_r[BIT_FAULT_EXIT]) begin
        if (!flag_r) fault_nxt = 1'b0;
      end else begin
        fault_nxt = 1'b0;
      end
    end

    if (running_r && count_w == (ctrl2_r[BIT_CASCADE] ? cmp_r : {16'h0000, cmp_r[15:0]})) begin
      events[IRQ_MATCH] = 1'b1;
    end
    if (period_edge) events[IRQ_PERIOD] = 1'b1;

    if (rd_in) begin
      case (addr_in)
        ADDR_CTRL2:      rdata_nxt = ctrl2_r & CTRL2_WMASK;
        ADDR_CTRL1:      rdata_nxt = {15'h0000, enable_r};
        ADDR_COMPARE:    rdata_nxt = cmp_r[15:0];
        ADDR_PERIOD:     rdata_nxt = per_r[15:0];
        ADDR_FAULT:      rdata_nxt = {14'h0000, flag_r, fault_in};
        ADDR_IRQ_STATUS: rdata_nxt = {12'h000, stat_r};
        ADDR_IRQ_MASK:   rdata_nxt = {12'h000, mask_r};
        ADDR_TIMER:      rdata_nxt = count_w[15:0];
        default:         rdata_nxt = 16'h0000;
      endcase
    end

    // read clears, but a new event in the same cycle survives
    stat_nxt = ((rd_in && addr_in == ADDR_IRQ_STATUS) ? '0 : stat_r) | events;

    // pwm: high from period start until the compare match
    raw_out = running_r && (count_w < (ctrl2_r[BIT_CASCADE] ? cmp_r : {16'h0000, cmp_r[15:0]}));
    if (fault_nxt) begin
      pin_nxt = ctrl2_r[BIT_FAULT_LEVEL];
      oe_nxt  = !ctrl2_r[BIT_FAULT_TRI] && !ctrl2_r[BIT_OUT_TRI];
    end else begin
      pin_nxt = raw_out ^ ctrl2_r[BIT_INVERT];
      oe_nxt  = !ctrl2_r[BIT_OUT_TRI];
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl2_r   <= CTRL2_RESET;
      enable_r  <= 1'b0;
      cmp_r     <= '0;
      per_r     <= {16'h0000, PERIOD_RESET};
      fault_r   <= 1'b0;
      flag_r    <= 1'b0;
      running_r <= 1'b0;
      stat_r    <= '0;
      mask_r    <= '0;
      rdata_r   <= 16'h0000;
      pin_r     <= 1'b0;
      oe_r      <= 1'b1;
      trig_r    <= 1'b0;
    end else begin
      ctrl2_r   <= ctrl2_nxt;
      enable_r  <= enable_nxt;
      cmp_r     <= cmp_nxt;
      per_r     <= per_nxt;
      fault_r   <= fault_nxt;
      flag_r    <= flag_nxt;
      running_r <= running_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      rdata_r   <= rdata_nxt;
      pin_r     <= pin_nxt;
      oe_r      <= oe_nxt;
      trig_r    <= trig_nxt;
    end
  end

  assign rdata_out  = rdata_r;
  assign pin_o_out  = pin_r;
  assign pin_oe_out = oe_r;
  assign trig_out   = trig_r;
  assign irq_out    = |(stat_r & mask_r);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  AST_FAULT_LEVEL: assert property (fault_in && !ctrl2_r[BIT_FAULT_TRI] |=> pin_o_out == $past(ctrl2_r[BIT_FAULT_LEVEL]))
    else $error("fault level not driven");
  AST_FAULT_TRI: assert property (fault_in && ctrl2_r[BIT_FAULT_TRI] |=> !pin_oe_out)
    else $error("pin not released on fault");
  AST_OUT_TRI: assert property (ctrl2_r[BIT_OUT_TRI] |=> !pin_oe_out)
    else $error("pin driven while tristated");
  AST_UNIMPL: assert property (rd_in && addr_in == ADDR_CTRL2 |=> rdata_out[11:9] == 3'h0)
    else $error("unimplemented bits read nonzero");
  AST_OFF_TRIG: assert property (enable_r && !enable_nxt |=> trig_out ##1 !trig_out)
    else $error("no single trigger pulse on disable");
  AST_HELD_CLEAR: assert property (!ctrl2_r[BIT_TRIG_STATUS] |=> count_w == 32'h0)
    else $error("timer runs while status clear");
  AST_EXIT_SW: assert property (ctrl2_r[BIT_FAULT_EXIT] && fault_r && flag_r && !wr_in |=> fault_r)
    else $error("fault left without flag clear");
  AST_EXIT_HW: assert property (!ctrl2_r[BIT_FAULT_EXIT] && fault_r && !fault_in && period_edge |=> !fault_r)
    else $error("fault not left at period start");
  AST_INVERT: assert property (!fault_nxt && !fault_r |=> pin_o_out == ($past(raw_out) ^ $past(ctrl2_r[BIT_INVERT])))
    else $error("invert not applied");
  AST_IDLE_LEVEL: assert property (!fault_nxt && !running_r |=> pin_o_out == $past(ctrl2_r[BIT_INVERT]))
    else $error("idle pin level ignores invert");
  AST_TRIG_WAIT: assert property (enable_r && ctrl2_r[BIT_TRIG_SEL] && !running_r && !src_hit |=> !running_r)
    else $error("started without trigger");
  AST_SRC: assert property (enable_r && ctrl2_r[BIT_TRIG_SEL] && src_hit && !wr_in |=> running_r)
    else $error("selected source ignored");
  AST_CASCADE: assert property (ctrl2_r[BIT_CASCADE] && wrap_w && !partner_wrap_in |-> !period_edge)
    else $error("cascade period ended alone");
  AST_MAP: assert property (!SRC_MAP[ctrl2_r[SRC_MSB:0]] |-> !src_hit)
    else $error("unmapped source fired");

  COV_FAULT: cover property (fault_in ##1 !fault_in [*2] ##1 !fault_r);
  COV_TRIG: cover property (enable_r && ctrl2_r[BIT_TRIG_SEL] && src_hit ##1 running_r);
  COV_OFF: cover property (trig_out);
  COV_IRQ: cover property (irq_out);
endmodule

// file: pkg/compare_pkg.sv
package compare_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0]  ADDR_CTRL2       = 4'h0;
  localparam logic [3:0]  ADDR_CTRL1       = 4'h1;
  localparam logic [3:0]  ADDR_COMPARE     = 4'h2;
  localparam logic [3:0]  ADDR_PERIOD      = 4'h3;
  localparam logic [3:0]  ADDR_FAULT       = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h6;
  localparam logic [3:0]  ADDR_TIMER       = 4'h7;
  // ----------------------------------------
  // compare_control_two fields
  // ----------------------------------------
  localparam int          BIT_FAULT_EXIT   = 15;
  localparam int          BIT_FAULT_LEVEL  = 14;
  localparam int          BIT_FAULT_TRI    = 13;
  localparam int          BIT_INVERT       = 12;
  localparam int          BIT_CASCADE      = 8;
  localparam int          BIT_TRIG_SEL     = 7;
  localparam int          BIT_TRIG_STATUS  = 6;
  localparam int          BIT_OUT_TRI      = 5;
  localparam int          SRC_MSB          = 4;
  localparam logic [15:0] CTRL2_WMASK      = 16'hf1ff;
  localparam logic [15:0] CTRL2_RESET      = 16'h000c;
  // ----------------------------------------
  // control one and status fields
  // ----------------------------------------
  localparam int          BIT_ENABLE       = 0;
  localparam int          BIT_FAULT_IN     = 0;
  localparam int          BIT_FAULT_FLAG   = 1;
  localparam int          IRQ_MATCH        = 0;
  localparam int          IRQ_PERIOD       = 1;
  localparam int          IRQ_FAULT        = 2;
  localparam int          IRQ_OFF_TRIG     = 3;
  localparam int          IRQ_W            = 4;
  localparam logic [15:0] PERIOD_RESET     = 16'hffff;
endpackage

// file: tb/compare_load.sv
module compare_load (
  input  wire logic sys_clk_in,  // clock
  input  wire logic pin_o_in,    // level the channel drives
  input  wire logic pin_oe_in,   // channel drive enable
  output logic      level_out    // level seen on the wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r;
  // ----------------------------------------
  // wire model
  // ----------------------------------------
  // no pull on this net: a released pin shows the inverse of the last driven level
  always_ff @(posedge sys_clk_in) begin
    if (pin_oe_in) last_r <= pin_o_in;
  end
  assign level_out = pin_oe_in ? pin_o_in : ~last_r;
endmodule

// file: tb/tb_output_compare_control_two.sv
module tb_output_compare_control_two import compare_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_in = 1'h0, rst_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0;
  logic        fault_in = 1'h0, partner_wrap_in = 1'h0, rd_d = 1'h0, look = 1'h0;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0, rdata_out;
  logic [31:0] src_in = 32'h0;
  logic        pin_o_out, pin_oe_out, trig_out, irq_out, level;
  logic [31:0] note_q[$];
  int          err_count = 0, tests_run = 0;

  output_compare_control_two uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .src_in(src_in),
    .fault_in(fault_in), .partner_wrap_in(partner_wrap_in), .pin_o_out(pin_o_out),
    .pin_oe_out(pin_oe_out), .trig_out(trig_out), .irq_out(irq_out));
  compare_load load (.sys_clk_in(sys_clk_in), .pin_o_in(pin_o_out), .pin_oe_in(pin_oe_out), .level_out(level));

  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one bus cycle; a read or a look notes the mask and value it expects
  task automatic step(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d,
                      input logic lk, input logic [15:0] m, input logic [15:0] e);
    @(posedge sys_clk_in);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    look <= lk;
    if (r || lk) note_q.push_back({m, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    step(1'h1, 1'h0, a, d, 1'h0, 16'h0, 16'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    step(1'h0, 1'h1, a, 16'h0, 1'h0, m, e);
  endtask
  // look bits: irq, trigger out, drive enable, wire level
  task automatic lk(input logic [3:0] m, input logic [3:0] e);
    step(1'h0, 1'h0, 4'h0, 16'h0, 1'h1, {12'h0, m}, {12'h0, e});
  endtask
  task automatic idle(input int n);
    repeat (n) step(1'h0, 1'h0, 4'h0, 16'h0, 1'h0, 16'h0, 16'h0);
  endtask
  task automatic pulse(input logic [31:0] v);
    idle(1);
    src_in <= v;
    partner_wrap_in <= v[31];
    idle(1);
    src_in <= 32'h0;
  endtask

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge sys_clk_in) rd_d <= rd_in;
  always @(negedge sys_clk_in) begin
    logic [31:0] n;
    if (rd_d) begin
      n = note_q.pop_front();
      chk(rdata_out & n[31:16], n[15:0]);
    end
    if (look) begin
      n = note_q.pop_front();
      chk({12'h0, irq_out, trig_out, pin_oe_out, level} & n[31:16], n[15:0]);
    end
  end

  initial begin
    #(20 * 3000);
    err_count++;
    wrap_up();
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    void'($urandom(61));
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'h0;
    rd(ADDR_CTRL2, 16'hffff, CTRL2_RESET);
    rd(4'h8, 16'hffff, 16'h0000);
    lk(4'hf, 4'h2);
    wr(ADDR_CTRL2, 16'hffff);
    rd(ADDR_CTRL2, 16'hffff, 16'hf1bf);
    idle(2);
    lk(4'h2, 4'h0);
    wr(ADDR_PERIOD, 16'h00ff);
    wr(ADDR_COMPARE, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0004);
    wr(ADDR_CTRL2, 16'hc08c);
    wr(ADDR_CTRL1, 16'h0001);
    idle(3);
    rd(ADDR_TIMER, 16'hffff, 16'h0000);
    pulse($urandom & 32'hffff_efff);
    rd(ADDR_CTRL2, 16'hffff, 16'hc08c);
    pulse(32'h0000_1000);
    rd(ADDR_CTRL2, 16'hffff, 16'hc0cc);
    lk(4'hf, 4'h2);
    idle(1);
    fault_in <= 1'h1;
    idle(3);
    lk(4'hf, 4'hb);
    rd(ADDR_IRQ_STATUS, 16'h0004, 16'h0004);
    idle(2);
    lk(4'h8, 4'h0);
    fault_in <= 1'h0;
    idle(300);
    lk(4'h3, 4'h3);
    rd(ADDR_FAULT, 16'h0003, 16'h0002);
    wr(ADDR_FAULT, 16'h0000);
    idle(300);
    lk(4'h3, 4'h2);
    wr(ADDR_CTRL2, 16'h208c);
    pulse(32'h0000_1000);
    fault_in <= 1'h1;
    idle(3);
    lk(4'h2, 4'h0);
    fault_in <= 1'h0;
    idle(300);
    lk(4'h3, 4'h2);
    wr(ADDR_CTRL2, 16'h108c);
    pulse(32'h0000_1000);
    idle(2);
    lk(4'h3, 4'h3);
    wr(ADDR_CTRL2, 16'h1080);
    wr(ADDR_CTRL1, 16'h0000);
    lk(4'h4, 4'h4);
    lk(4'h4, 4'h0);
    // sync mode runs without a trigger and restarts on each source pulse
    wr(ADDR_CTRL2, 16'h000c);
    wr(ADDR_CTRL1, 16'h0001);
    idle(20);
    pulse(32'h0000_1000);
    rd(ADDR_TIMER, 16'hffff, 16'h0001);
    rd(ADDR_CTRL2, 16'hffff, 16'h004c);
    // cascade: a short period only ends when the partner wraps too
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_CTRL2, 16'h014c);
    pulse(32'h0000_1000);
    rd(ADDR_IRQ_STATUS, 16'h0008, 16'h0008);
    idle(10);
    rd(ADDR_IRQ_STATUS, 16'h0002, 16'h0000);
    partner_wrap_in <= 1'h1;
    idle(10);
    partner_wrap_in <= 1'h0;
    rd(ADDR_IRQ_STATUS, 16'h0002, 16'h0002);
    idle(2);
    wrap_up();
  end
endmodule
